// >>> rtl/nax_pkg.sv
package nax_pkg;

    // ==========================================================
    // datapath widths
    localparam int ACC_W = 4;
    localparam int REG_IDX_W = 4;
    localparam int REG_DEPTH = 16;
    localparam int ROM_W = 10;
    localparam int PAGE_W = 2;
    localparam int PAIR_W = 8;
    localparam int PORT_SLOTS = 4;
    localparam int PORT_IDX_W = 3;
    localparam int PORT_BUS_W = PORT_SLOTS * ACC_W;

    // ==========================================================
    // field positions
    localparam int ACC_MSB = 3;
    localparam int ROM_HI_LSB = 4;
    localparam int ROM_LO_LSB = 0;
    localparam int IMM_HI_LSB = 4;
    localparam int IMM_LO_LSB = 0;

    // ==========================================================
    // reset values
    localparam logic [ACC_W-1:0] ACC_RST = 4'h0;
    localparam logic CARRY_RST = 1'b0;
    localparam logic [ACC_W-1:0] REG_RST = 4'h0;
    localparam logic [PORT_BUS_W-1:0] PORT_OUT_RST = 16'h0000;
    localparam logic [ACC_W-1:0] ACC_ZERO = 4'h0;
    localparam logic [ACC_W-1:0] ACC_ONE = 4'h1;

    // ==========================================================
    // port index codes that exist on the device
    localparam logic [PORT_IDX_W-1:0] PORT_IDX_0 = 3'h0;
    localparam logic [PORT_IDX_W-1:0] PORT_IDX_1 = 3'h1;
    localparam logic [PORT_IDX_W-1:0] PORT_IDX_3 = 3'h3;
    localparam logic [PORT_IDX_W-1:0] PORT_IDX_4 = 3'h4;
    localparam logic BANK_LOW = 1'b0;
    localparam logic BANK_HIGH = 1'b1;

    // ==========================================================
    // operations issued by the instruction decoder
    typedef enum logic [4:0] {
        OP_NOP          = 5'h00,
        OP_AND_ROM_HI   = 5'h01,
        OP_AND_ROM_LO   = 5'h02,
        OP_AND_IMM      = 5'h03,
        OP_OR_REG       = 5'h04,
        OP_OR_ROM_HI    = 5'h05,
        OP_OR_ROM_LO    = 5'h06,
        OP_OR_IMM       = 5'h07,
        OP_XOR_REG      = 5'h08,
        OP_XOR_ROM_HI   = 5'h09,
        OP_XOR_ROM_LO   = 5'h0A,
        OP_XOR_IMM      = 5'h0B,
        OP_INC          = 5'h0C,
        OP_ROTATE_LEFT  = 5'h0D,
        OP_ROTATE_RST   = 5'h0E,
        OP_IN_PORT      = 5'h0F,
        OP_OUT_PORT     = 5'h10,
        OP_AND_PORT     = 5'h11,
        OP_OR_PORT      = 5'h12,
        OP_XOR_PORT     = 5'h13,
        OP_OUT_PAIR_IMM = 5'h14,
        OP_LD_REG       = 5'h15,
        OP_LD_ROM_HI    = 5'h16,
        OP_LD_ROM_LO    = 5'h17,
        OP_LD_IMM       = 5'h18,
        OP_ST_REG       = 5'h19,
        OP_LD_PAIR_IMM  = 5'h1A
    } nax_op_t;

endpackage

// >>> rtl/nax_regfile.sv
`timescale 1ns/1ps
module nax_regfile
    import nax_pkg::*;
#(
    parameter int IDX_W = REG_IDX_W,
    parameter int DEPTH = REG_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // single nibble read
    input wire logic rd_bank,
    input wire logic [IDX_W-1:0] rd_idx,
    output logic [ACC_W-1:0] rd_data,
    // single nibble write
    input wire logic wr_en,
    input wire logic wr_bank,
    input wire logic [IDX_W-1:0] wr_idx,
    input wire logic [ACC_W-1:0] wr_data,
    // pair write, high bank takes the upper nibble
    input wire logic pair_en,
    input wire logic [IDX_W-1:0] pair_idx,
    input wire logic [PAIR_W-1:0] pair_data,
    // next value of pair 0, used for the rom operand address
    output logic [PAIR_W-1:0] pair0_d
);

    // ==========================================================
    // storage: low bank at 0..DEPTH-1, high bank above it
    localparam int ENTRIES = 2 * DEPTH;

    logic [ACC_W-1:0] mem_q [ENTRIES];
    logic [ACC_W-1:0] ent_d [ENTRIES];

    genvar g;
    generate
        for (g = 0; g < ENTRIES; g++) begin : g_ent
            localparam logic BANK = (g >= DEPTH) ? BANK_HIGH : BANK_LOW;
            localparam logic [IDX_W-1:0] IDX = IDX_W'(g % DEPTH);
            wire sel_one = wr_en && (wr_bank == BANK) && (wr_idx == IDX);
            wire sel_pair = pair_en && (pair_idx == IDX);
            wire [ACC_W-1:0] pair_nib = BANK ?
                pair_data[IMM_HI_LSB +: ACC_W] :
                pair_data[IMM_LO_LSB +: ACC_W];
            // one write source per cycle; single write checked first
            assign ent_d[g] = sel_one ? wr_data :
                              sel_pair ? pair_nib : mem_q[g];
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    mem_q[g] <= REG_RST;
                end else begin
                    mem_q[g] <= ent_d[g];
                end
            end
        end
    endgenerate

    // ==========================================================
    // read side
    assign rd_data = mem_q[{rd_bank, rd_idx}];
    // high bank entry 0 is the upper half of the address byte
    assign pair0_d = {ent_d[DEPTH], ent_d[0]};

endmodule

// >>> rtl/nax_alu.sv
`timescale 1ns/1ps
module nax_alu
    import nax_pkg::*;
(
    // operation and operands
    input wire nax_op_t op,
    input wire logic [ACC_W-1:0] acc,
    input wire logic [ACC_W-1:0] opnd,
    // results
    output logic [ACC_W-1:0] acc_d,
    output logic acc_we,
    output logic carry_d,
    output logic carry_we,
    output logic reset_req
);

    // ==========================================================
    // shared terms
    wire [ACC_W-1:0] and_v = acc & opnd;
    wire [ACC_W-1:0] or_v = acc | opnd;
    wire [ACC_W-1:0] xor_v = acc ^ opnd;
    wire [ACC_W-1:0] inc_v = acc + ACC_ONE;
    wire [ACC_W-1:0] rot_v = {acc[ACC_MSB-1:0], acc[ACC_MSB]};
    wire msb_and = acc[ACC_MSB] & opnd[ACC_MSB];
    wire acc_zero = (acc == ACC_ZERO);

    // ==========================================================
    // per operation result and carry; stores leave both alone
    always_comb begin
        acc_d = acc;
        acc_we = 1'b0;
        carry_d = CARRY_RST;
        carry_we = 1'b0;
        reset_req = 1'b0;
        unique case (op)
            OP_AND_ROM_HI, OP_AND_ROM_LO, OP_AND_IMM, OP_AND_PORT: begin
                acc_d = and_v;
                carry_d = msb_and;
                acc_we = 1'b1;
                carry_we = 1'b1;
            end
            OP_OR_REG, OP_OR_ROM_HI, OP_OR_ROM_LO, OP_OR_IMM,
            OP_OR_PORT: begin
                acc_d = or_v;
                carry_d = 1'b0;
                acc_we = 1'b1;
                carry_we = 1'b1;
            end
            OP_XOR_REG, OP_XOR_ROM_HI, OP_XOR_ROM_LO, OP_XOR_IMM,
            OP_XOR_PORT: begin
                acc_d = xor_v;
                carry_d = msb_and;
                acc_we = 1'b1;
                carry_we = 1'b1;
            end
            OP_INC: begin
                acc_d = inc_v;
                carry_d = (inc_v == ACC_ZERO);
                acc_we = 1'b1;
                carry_we = 1'b1;
            end
            OP_ROTATE_LEFT: begin
                acc_d = rot_v;
                carry_d = acc[ACC_MSB];
                acc_we = 1'b1;
                carry_we = 1'b1;
            end
            OP_ROTATE_RST: begin
                // a zero accumulator resets the chip instead of rotating
                reset_req = acc_zero;
                acc_d = rot_v;
                carry_d = acc[ACC_MSB];
                acc_we = !acc_zero;
                carry_we = !acc_zero;
            end
            OP_IN_PORT, OP_LD_REG, OP_LD_ROM_HI, OP_LD_ROM_LO,
            OP_LD_IMM: begin
                acc_d = opnd;
                carry_d = 1'b0;
                acc_we = 1'b1;
                carry_we = 1'b1;
            end
            OP_NOP, OP_OUT_PORT, OP_OUT_PAIR_IMM, OP_ST_REG,
            OP_LD_PAIR_IMM: begin
                acc_d = acc;
            end
            default: begin
                acc_d = acc;
            end
        endcase
    end

endmodule

// >>> rtl/nax_exec.sv
`timescale 1ns/1ps
// Notes on behaviour
// - and with rom nibble; carry is acc bit 3 and word bit 7 or 3
// - and with immediate nibble; carry is acc bit 3 and immediate bit 3
// - or with low or high bank register; carry cleared
// - or with rom upper or lower nibble; carry cleared
// - xor with bank register; carry is acc bit 3 and register bit 3
// - xor with rom nibble; carry is acc bit 3 and word bit 7 or 3
// - xor with immediate nibble; carry is acc bit 3 and immediate bit 3
// - increment modulo 16; carry set only when result is zero
// - rotate left, old bit 3 to bit 0 and to carry
// - rotate or reset: zero accumulator raises internal reset, else rotate
// - read port nibble into accumulator; carry cleared
// - write accumulator into selected port output latch
// - and with port nibble; carry is acc bit 3 and port bit 3
// - or with port nibble; carry cleared
// - xor with port nibble; carry is acc bit 3 and port bit 3
// - write immediate byte to high and low port of one index together
// - load bank register into accumulator; carry cleared
// - load rom bits 7-4 into accumulator, ignore bit 9; carry cleared
// - load rom bits 3-0 into accumulator, ignore bit 8; carry cleared
// - load immediate nibble into accumulator; carry cleared
// - store accumulator into bank register; carry kept
// - immediate byte into register pair, high bank gets upper nibble
// - rom address upper two bits from page, rest from pair 0
// - rom words are 10 bits; nibbles come from the low 8 bits
module nax_exec
    import nax_pkg::*;
#(
    parameter int IDX_W = REG_IDX_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // operation issue from the decoder
    input wire logic op_valid,
    input wire nax_op_t op_code,
    input wire logic op_bank,
    input wire logic [IDX_W-1:0] op_reg_idx,
    input wire logic [PORT_IDX_W-1:0] op_port_idx,
    input wire logic [PAIR_W-1:0] imm_byte,
    // rom page from the page control register
    input wire logic [PAGE_W-1:0] rom_page_reg,
    // program memory operand fetch
    output logic [ROM_W-1:0] rom_addr_q,
    input wire logic [ROM_W-1:0] rom_data,
    // port pins, slot order 0,1,3,4 from the low bits up
    input wire logic [PORT_BUS_W-1:0] port_in_low,
    input wire logic [PORT_BUS_W-1:0] port_in_high,
    output logic [PORT_BUS_W-1:0] port_out_low_q,
    output logic [PORT_BUS_W-1:0] port_out_high_q,
    // state and events
    output logic [ACC_W-1:0] acc_q,
    output logic carry_flag_q,
    output logic internal_reset_q,
    output logic op_done_q,
    output logic bad_port_q
);

    // ==========================================================
    // port index to latch slot; bit 2 of the answer is "exists"
    function automatic logic [2:0] port_slot(
        input logic [PORT_IDX_W-1:0] idx
    );
        logic [2:0] r;
        r = 3'h0;
        unique case (idx)
            PORT_IDX_0: r = 3'h4;
            PORT_IDX_1: r = 3'h5;
            PORT_IDX_3: r = 3'h6;
            PORT_IDX_4: r = 3'h7;
            default: r = 3'h0;
        endcase
        return r;
    endfunction

    // ==========================================================
    // port pin synchronisers; only the second stage is read
    logic [PORT_BUS_W-1:0] pin_low_meta_q;
    logic [PORT_BUS_W-1:0] pin_high_meta_q;
    logic [PORT_BUS_W-1:0] pin_low_q;
    logic [PORT_BUS_W-1:0] pin_high_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_low_meta_q <= PORT_OUT_RST;
            pin_high_meta_q <= PORT_OUT_RST;
            pin_low_q <= PORT_OUT_RST;
            pin_high_q <= PORT_OUT_RST;
        end else begin
            pin_low_meta_q <= port_in_low;
            pin_high_meta_q <= port_in_high;
            pin_low_q <= pin_low_meta_q;
            pin_high_q <= pin_high_meta_q;
        end
    end

    // ==========================================================
    // operation class decode
    wire op_go = op_valid;
    wire [2:0] slot_info = port_slot(op_port_idx);
    wire port_ok = slot_info[2];
    wire [1:0] slot = slot_info[1:0];
    wire uses_port = op_code inside {OP_IN_PORT, OP_OUT_PORT,
        OP_AND_PORT, OP_OR_PORT, OP_XOR_PORT, OP_OUT_PAIR_IMM};
    wire uses_rom_hi = op_code inside {OP_AND_ROM_HI, OP_OR_ROM_HI,
        OP_XOR_ROM_HI, OP_LD_ROM_HI};
    wire uses_rom_lo = op_code inside {OP_AND_ROM_LO, OP_OR_ROM_LO,
        OP_XOR_ROM_LO, OP_LD_ROM_LO};
    wire uses_imm = op_code inside {OP_AND_IMM, OP_OR_IMM,
        OP_XOR_IMM, OP_LD_IMM};
    // a missing port index drops the whole operation
    wire op_bad = op_go && uses_port && !port_ok;
    wire op_ok = op_go && !op_bad;

    // ==========================================================
    // operand selection
    logic [ACC_W-1:0] reg_rd;
    wire [ACC_W-1:0] rom_hi = rom_data[ROM_HI_LSB +: ACC_W];
    wire [ACC_W-1:0] rom_lo = rom_data[ROM_LO_LSB +: ACC_W];
    wire [ACC_W-1:0] imm_nibble = imm_byte[IMM_LO_LSB +: ACC_W];
    wire [3:0] slot_lsb = {slot, 2'b00};
    wire [ACC_W-1:0] pin_nib = (op_bank == BANK_HIGH) ?
        pin_high_q[slot_lsb +: ACC_W] : pin_low_q[slot_lsb +: ACC_W];
    // rom nibbles never look at bits 9 and 8
    wire [ACC_W-1:0] opnd = uses_rom_hi ? rom_hi :
                            uses_rom_lo ? rom_lo :
                            uses_imm ? imm_nibble :
                            uses_port ? pin_nib :
                            reg_rd;

    // ==========================================================
    // arithmetic and logic
    logic [ACC_W-1:0] alu_acc;
    logic alu_acc_we;
    logic alu_carry;
    logic alu_carry_we;
    logic alu_reset;

    nax_alu u_alu (
        .op(op_code),
        .acc(acc_q),
        .opnd(opnd),
        .acc_d(alu_acc),
        .acc_we(alu_acc_we),
        .carry_d(alu_carry),
        .carry_we(alu_carry_we),
        .reset_req(alu_reset)
    );

    // ==========================================================
    // register file writes
    wire reg_wr = op_ok && (op_code == OP_ST_REG);
    wire pair_wr = op_ok && (op_code == OP_LD_PAIR_IMM);
    logic [PAIR_W-1:0] pair0_d;

    nax_regfile #(
        .IDX_W(IDX_W),
        .DEPTH(REG_DEPTH)
    ) u_regs (
        .clk(clk),
        .reset_n(reset_n),
        .rd_bank(op_bank),
        .rd_idx(op_reg_idx),
        .rd_data(reg_rd),
        .wr_en(reg_wr),
        .wr_bank(op_bank),
        .wr_idx(op_reg_idx),
        .wr_data(acc_q),
        .pair_en(pair_wr),
        .pair_idx(op_reg_idx),
        .pair_data(imm_byte),
        .pair0_d(pair0_d)
    );

    // ==========================================================
    // rom operand address; registered so a pair 0 write is seen
    // by the very next operation
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rom_addr_q <= '0;
        end else begin
            rom_addr_q <= {rom_page_reg, pair0_d};
        end
    end

    // ==========================================================
    // accumulator and carry
    wire acc_load = op_ok && alu_acc_we;
    wire carry_load = op_ok && alu_carry_we;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_q <= ACC_RST;
            carry_flag_q <= CARRY_RST;
        end else begin
            if (acc_load) begin
                acc_q <= alu_acc;
            end
            if (carry_load) begin
                carry_flag_q <= alu_carry;
            end
        end
    end

    // ==========================================================
    // port output latches; pair write drives both banks at once
    wire out_one = op_ok && (op_code == OP_OUT_PORT);
    wire out_pair = op_ok && (op_code == OP_OUT_PAIR_IMM);
    wire [ACC_W-1:0] pair_hi_nib = imm_byte[IMM_HI_LSB +: ACC_W];
    wire [ACC_W-1:0] pair_lo_nib = imm_byte[IMM_LO_LSB +: ACC_W];

    genvar s;
    generate
        for (s = 0; s < PORT_SLOTS; s++) begin : g_port
            wire hit = (slot == 2'(s));
            wire lo_one = out_one && hit && (op_bank == BANK_LOW);
            wire hi_one = out_one && hit && (op_bank == BANK_HIGH);
            wire both = out_pair && hit;
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    port_out_low_q[s*ACC_W +: ACC_W] <= ACC_ZERO;
                    port_out_high_q[s*ACC_W +: ACC_W] <= ACC_ZERO;
                end else begin
                    if (lo_one) begin
                        port_out_low_q[s*ACC_W +: ACC_W] <= acc_q;
                    end else if (both) begin
                        port_out_low_q[s*ACC_W +: ACC_W] <= pair_lo_nib;
                    end
                    if (hi_one) begin
                        port_out_high_q[s*ACC_W +: ACC_W] <= acc_q;
                    end else if (both) begin
                        port_out_high_q[s*ACC_W +: ACC_W] <= pair_hi_nib;
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // event pulses; the reset request is held for one cycle only,
    // the chip reset generator is expected to stretch it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            internal_reset_q <= 1'b0;
            op_done_q <= 1'b0;
            bad_port_q <= 1'b0;
        end else begin
            internal_reset_q <= op_ok && alu_reset;
            op_done_q <= op_ok;
            bad_port_q <= op_bad;
        end
    end

endmodule

// >>> tb/nax_rom_model.sv
`timescale 1ns/1ps
module nax_rom_model
    import nax_pkg::*;
(
    // operand address from the block
    input wire logic [ROM_W-1:0] rom_addr,
    // ten bit word, read back in the same cycle
    output logic [ROM_W-1:0] rom_data
);
    // ==========================================================
    // contents
    // words repeat across pages and the top two bits copy address bits 1 and 0, so a
    // nibble read that strays into bits 9 or 8 shows up wherever those two bits are not both zero
    assign rom_data = {rom_addr[1:0], rom_addr[7:0] ^ 8'h96};
endmodule

// >>> tb/nax_exec_properties.sv
`timescale 1ns/1ps
module nax_exec_props
    import nax_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // operation issue
    input wire logic op_valid,
    input wire nax_op_t op_code,
    input wire logic [PAIR_W-1:0] imm_byte,
    input wire logic [PAGE_W-1:0] rom_page_reg,
    // state and events
    input wire logic [ROM_W-1:0] rom_addr_q,
    input wire logic [ACC_W-1:0] acc_q,
    input wire logic carry_flag_q,
    input wire logic internal_reset_q,
    input wire logic op_done_q,
    input wire logic bad_port_q
);
    // ==========================================================
    // view of the previous issue, so each result is tied to its cause
    logic v_q;
    logic up_q;
    nax_op_t op_q;
    logic [ACC_W-1:0] a_q;
    logic [ACC_W-1:0] i_q;
    logic c_q;
    logic [PAGE_W-1:0] p_q;
    wire [ACC_W-1:0] rot_q = {a_q[2:0], a_q[3]};
    wire rlz_q = v_q && op_q == OP_ROTATE_RST;

    // valid and liveness flags are cleared so no check fires on stale data
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            v_q <= 1'b0;
            up_q <= 1'b0;
        end else begin
            v_q <= op_valid;
            up_q <= 1'b1;
        end
    end

    // operand copies need no reset, they are only read behind v_q or up_q
    always_ff @(posedge clk) begin
        op_q <= op_code;
        a_q <= acc_q;
        i_q <= imm_byte[3:0];
        c_q <= carry_flag_q;
        p_q <= rom_page_reg;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // ==========================================================
    // assertions
    a_inc_wrap: assert property (v_q && op_q == OP_INC |->
        acc_q == a_q + 4'h1 && carry_flag_q == (a_q == 4'hF))
        else $error("increment result or carry wrong");
    a_and_imm: assert property (v_q && op_q == OP_AND_IMM |->
        acc_q == (a_q & i_q) && carry_flag_q == (a_q[3] & i_q[3]))
        else $error("and with immediate wrong");
    a_load_imm: assert property (v_q && op_q == OP_LD_IMM |->
        acc_q == i_q && !carry_flag_q)
        else $error("immediate load wrong");
    a_rotate_left: assert property (v_q && op_q == OP_ROTATE_LEFT
        |-> acc_q == rot_q && carry_flag_q == a_q[3])
        else $error("rotate result wrong");
    a_reset_cause: assert property (
        internal_reset_q == (rlz_q && a_q == 4'h0))
        else $error("internal reset without zero rotate");
    a_done_follows: assert property (op_valid |=>
        op_done_q != bad_port_q)
        else $error("done and refusal pulses disagree");
    a_page_bits: assert property (up_q |->
        rom_addr_q[9:8] == p_q)
        else $error("rom page bits wrong");
    a_store_carry: assert property (v_q && op_q == OP_ST_REG |->
        carry_flag_q == c_q && acc_q == a_q)
        else $error("store changed carry or accumulator");
    a_or_clears: assert property (v_q && !bad_port_q &&
        op_q inside {OP_OR_REG, OP_OR_ROM_HI, OP_OR_ROM_LO, OP_OR_PORT}
        |-> !carry_flag_q) else $error("or left carry set");

    // ==========================================================
    // covers
    c_wrap: cover property (v_q && op_q == OP_INC && a_q == 4'hF);
    c_reset: cover property (internal_reset_q);
    c_refuse: cover property (bad_port_q);
endmodule

bind nax_exec nax_exec_props i_nax_exec_props (
    .clk(clk),
    .reset_n(reset_n),
    .op_valid(op_valid),
    .op_code(op_code),
    .imm_byte(imm_byte),
    .rom_page_reg(rom_page_reg),
    .rom_addr_q(rom_addr_q),
    .acc_q(acc_q),
    .carry_flag_q(carry_flag_q),
    .internal_reset_q(internal_reset_q),
    .op_done_q(op_done_q),
    .bad_port_q(bad_port_q)
);

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
    import nax_pkg::*;
    // ==========================================================
    // stimulus and observed signals
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic op_valid = 1'b0;
    nax_op_t op_code = OP_NOP;
    logic op_bank = 1'b0;
    logic [REG_IDX_W-1:0] op_reg_idx = 4'h0;
    logic [PORT_IDX_W-1:0] op_port_idx = 3'h0;
    logic [PAIR_W-1:0] imm_byte = 8'h00;
    logic [PAGE_W-1:0] rom_page_reg = 2'h2;
    logic [PORT_BUS_W-1:0] port_in_low = 16'h9C5A;
    logic [PORT_BUS_W-1:0] port_in_high = 16'h36E8;
    logic [ROM_W-1:0] rom_addr_q;
    logic [ROM_W-1:0] rom_data;
    logic [PORT_BUS_W-1:0] port_out_low_q;
    logic [PORT_BUS_W-1:0] port_out_high_q;
    logic [ACC_W-1:0] acc_q;
    logic carry_flag_q;
    logic internal_reset_q;
    logic op_done_q;
    logic bad_port_q;
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;

    always #20 clk = ~clk;

    nax_exec i_nax_exec (.clk(clk), .reset_n(reset_n), .op_valid(op_valid),
        .op_code(op_code), .op_bank(op_bank), .op_reg_idx(op_reg_idx),
        .op_port_idx(op_port_idx), .imm_byte(imm_byte),
        .rom_page_reg(rom_page_reg), .rom_addr_q(rom_addr_q),
        .rom_data(rom_data), .port_in_low(port_in_low),
        .port_in_high(port_in_high), .port_out_low_q(port_out_low_q),
        .port_out_high_q(port_out_high_q), .acc_q(acc_q),
        .carry_flag_q(carry_flag_q), .internal_reset_q(internal_reset_q),
        .op_done_q(op_done_q), .bad_port_q(bad_port_q));
    nax_rom_model i_nax_rom_model (.rom_addr(rom_addr_q), .rom_data(rom_data));

    // ==========================================================
    // shared tasks
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // a hang is cut short well after the roughly 52 cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 400) begin
            n_fail = n_fail + 1;
            report_and_stop();
        end
    end

    task automatic chk(logic [15:0] seen, logic [15:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // sel packs bank in bit 7, port index in 6:4 and register index in 3:0
    task automatic issue(nax_op_t op, logic [7:0] sel, logic [7:0] imm);
        op_valid = 1'b1;
        op_code = op;
        op_bank = sel[7];
        op_port_idx = sel[6:4];
        op_reg_idx = sel[3:0];
        imm_byte = imm;
        @(negedge clk);
    endtask

    task automatic step(nax_op_t op, logic [7:0] sel, logic [7:0] imm,
                        logic [3:0] ea, logic ec);
        issue(op, sel, imm);
        chk(16'(acc_q), 16'(ea));
        chk(16'(carry_flag_q), 16'(ec));
        chk(16'(op_done_q), 16'h0001);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_imm();
        step(OP_LD_IMM, 8'h00, 8'hAF, 4'hF, 1'h0);
        step(OP_INC, 8'h00, 8'h00, 4'h0, 1'h1);
        step(OP_INC, 8'h00, 8'h00, 4'h1, 1'h0);
        step(OP_OR_IMM, 8'h00, 8'h06, 4'h7, 1'h0);
        step(OP_LD_IMM, 8'h00, 8'h09, 4'h9, 1'h0);
        step(OP_ROTATE_LEFT, 8'h00, 8'h00, 4'h3, 1'h1);
        step(OP_LD_IMM, 8'h00, 8'h0C, 4'hC, 1'h0);
        step(OP_AND_IMM, 8'h00, 8'h09, 4'h8, 1'h1);
        step(OP_XOR_IMM, 8'h00, 8'h0C, 4'h4, 1'h1);
        step(OP_ROTATE_RST, 8'h00, 8'h00, 4'h8, 1'h0);
        step(OP_ROTATE_RST, 8'h00, 8'h00, 4'h1, 1'h1);
        $display("test immediate done");
    endtask

    task automatic t_rom();
        step(OP_LD_PAIR_IMM, 8'h00, 8'h3E, 4'h1, 1'h1);
        chk(16'(rom_addr_q), 16'h023E);
        step(OP_LD_ROM_HI, 8'h00, 8'h00, 4'hA, 1'h0);
        step(OP_LD_ROM_LO, 8'h00, 8'h00, 4'h8, 1'h0);
        step(OP_AND_ROM_HI, 8'h00, 8'h00, 4'h8, 1'h1);
        step(OP_AND_ROM_LO, 8'h00, 8'h00, 4'h8, 1'h1);
        step(OP_XOR_ROM_HI, 8'h00, 8'h00, 4'h2, 1'h1);
        step(OP_OR_ROM_LO, 8'h00, 8'h00, 4'hA, 1'h0);
        step(OP_XOR_ROM_LO, 8'h00, 8'h00, 4'h2, 1'h1);
        step(OP_OR_ROM_HI, 8'h00, 8'h00, 4'hA, 1'h0);
        $display("test rom done");
    endtask

    task automatic t_regs();
        step(OP_LD_IMM, 8'h00, 8'h0F, 4'hF, 1'h0);
        step(OP_AND_IMM, 8'h00, 8'h09, 4'h9, 1'h1);
        step(OP_ST_REG, 8'h8F, 8'h00, 4'h9, 1'h1);
        step(OP_LD_IMM, 8'h00, 8'h02, 4'h2, 1'h0);
        step(OP_ST_REG, 8'h0F, 8'h00, 4'h2, 1'h0);
        step(OP_LD_REG, 8'h8F, 8'h00, 4'h9, 1'h0);
        step(OP_XOR_REG, 8'h8F, 8'h00, 4'h0, 1'h1);
        step(OP_OR_REG, 8'h0F, 8'h00, 4'h2, 1'h0);
        step(OP_LD_PAIR_IMM, 8'h05, 8'hC3, 4'h2, 1'h0);
        step(OP_LD_REG, 8'h85, 8'h00, 4'hC, 1'h0);
        step(OP_LD_REG, 8'h05, 8'h00, 4'h3, 1'h0);
        $display("test registers done");
    endtask

    task automatic t_ports();
        step(OP_LD_IMM, 8'h00, 8'h0F, 4'hF, 1'h0);
        step(OP_INC, 8'h00, 8'h00, 4'h0, 1'h1);
        step(OP_IN_PORT, 8'h00, 8'h00, 4'hA, 1'h0);
        step(OP_IN_PORT, 8'h10, 8'h00, 4'h5, 1'h0);
        step(OP_IN_PORT, 8'h30, 8'h00, 4'hC, 1'h0);
        step(OP_IN_PORT, 8'h40, 8'h00, 4'h9, 1'h0);
        step(OP_IN_PORT, 8'hB0, 8'h00, 4'h6, 1'h0);
        step(OP_LD_IMM, 8'h00, 8'h0F, 4'hF, 1'h0);
        step(OP_AND_PORT, 8'h30, 8'h00, 4'hC, 1'h1);
        step(OP_XOR_PORT, 8'h80, 8'h00, 4'h4, 1'h1);
        step(OP_OR_PORT, 8'h10, 8'h00, 4'h5, 1'h0);
        step(OP_OUT_PORT, 8'hB0, 8'h00, 4'h5, 1'h0);
        chk(port_out_high_q, 16'h0500);
        chk(port_out_low_q, 16'h0000);
        step(OP_OUT_PAIR_IMM, 8'h10, 8'h7D, 4'h5, 1'h0);
        chk(port_out_high_q, 16'h0570);
        chk(port_out_low_q, 16'h00D0);
        issue(OP_IN_PORT, 8'h20, 8'h00);
        chk(16'(acc_q), 16'h0005);
        chk({14'h0000, bad_port_q, op_done_q}, 16'h0002);
        $display("test ports done");
    endtask

    task automatic t_rlz();
        step(OP_LD_IMM, 8'h00, 8'h0F, 4'hF, 1'h0);
        step(OP_INC, 8'h00, 8'h00, 4'h0, 1'h1);
        step(OP_ROTATE_RST, 8'h00, 8'h00, 4'h0, 1'h1);
        chk(16'(internal_reset_q), 16'h0001);
        op_valid = 1'b0;
        @(negedge clk);
        chk(16'(internal_reset_q), 16'h0000);
        $display("test rotate or reset done");
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        chk(16'(rom_addr_q), 16'h0200);
        t_imm();
        t_rom();
        t_regs();
        t_ports();
        t_rlz();
        report_and_stop();
    end
endmodule
